// [inc/ddcr_defines.svh]
// Register indices, field positions, reset values and link constants
`ifndef DDCR_DEFINES_SVH
`define DDCR_DEFINES_SVH

`define DDCR_IDX_PINCFG  8'h21
`define DDCR_IDX_DP      8'h22
`define DDCR_IDX_MODE    8'h23
`define DDCR_IDX_BIST    8'h24
`define DDCR_IDX_ERRCNT  8'h25
`define DDCR_IDX_SCLH    8'h26
`define DDCR_IDX_SCLL    8'h27
`define DDCR_IDX_DP2     8'h28
`define DDCR_IDX_AUD     8'h2B
`define DDCR_IDX_PSEL    8'h34
`define DDCR_IDX_PROT    8'h50

`define DDCR_B_OVR       7
`define DDCR_B_PASS      6
`define DDCR_B_DEINV     5
`define DDCR_B_AUDT      1
`define DDCR_B_AUD4      0
`define DDCR_B_CKSUM     7
`define DDCR_B_DIV       6
`define DDCR_B_FAST      4
`define DDCR_B_COAX      3
`define DDCR_B_RPT       2
`define DDCR_B_VDIS      5
`define DDCR_B_DUAL      4
`define DDCR_B_PINCFG    3
`define DDCR_B_STEN      0
`define DDCR_B_P1SEL     1

`define DDCR_RST_PINCFG  8'h00
`define DDCR_RST_DP      8'h00
`define DDCR_RST_MODE    8'h20
`define DDCR_RST_BIST    8'h08
`define DDCR_RST_SCLH    8'h83
`define DDCR_RST_SCLL    8'h84
`define DDCR_RST_DP2     8'h00
`define DDCR_RST_AUD     8'h00
`define DDCR_RST_PSEL    8'h01
`define DDCR_MASK_DP2_WR 8'hEF
`define DDCR_MASK_AUD_WR 8'h03

`define DDCR_REMOTE_CLKSRC_ADDR 8'h14
`define DDCR_STRAP_SETTLE 2'h3

`endif

// [inc/ddcr_pkg.sv]
// Types shared by the configuration register block
package ddcr_pkg;
    typedef logic [7:0] ddcr_byte_t;
    typedef enum logic [1:0] {DDCR_RC_DIV4, DDCR_RC_DIV2, DDCR_RC_FAST} ddcr_rc_rate_t;
    typedef enum logic [1:0] {DDCR_PAD_FUNC, DDCR_PAD_TRI, DDCR_PAD_GPO, DDCR_PAD_GPI}
        ddcr_pad_mode_t;
endpackage : ddcr_pkg

// [inc/ddcr_pad_if.sv]
// Pin configuration and pad drive between register block and pad logic
`timescale 1ns/1ps
`default_nettype none
interface ddcr_pad_if #(parameter int N = 2);
    logic [N-1:0] dir;
    logic [N-1:0] en;
    logic [N-1:0] remote;
    logic [N-1:0] local_lvl;
    logic [N-1:0] remote_lvl;
    logic [N-1:0] func;
    logic [N-1:0] pad_out;
    logic [N-1:0] pad_oe;
    modport cfg (output dir, en, remote, local_lvl, remote_lvl, func,
                 input pad_out, pad_oe);
    modport pad (input dir, en, remote, local_lvl, remote_lvl, func,
                 output pad_out, pad_oe);
endinterface : ddcr_pad_if
`default_nettype wire

// [hw/ddcr_pad.sv]
// Pad drive selection for the two configurable pins
`timescale 1ns/1ps
`default_nettype none
module ddcr_pad
    import ddcr_pkg::*;
#(
    parameter int N = 2
)(
    input  wire logic aclk,
    input  wire logic aresetn,
    ddcr_pad_if.pad   p
);
    import ddcr_pkg::*;

    function automatic ddcr_pad_mode_t pad_mode(input logic dir, input logic en);
        unique case ({dir, en})
            2'b00:   pad_mode = DDCR_PAD_FUNC;
            2'b10:   pad_mode = DDCR_PAD_TRI;
            2'b01:   pad_mode = DDCR_PAD_GPO;
            2'b11:   pad_mode = DDCR_PAD_GPI;
        endcase
    endfunction : pad_mode

    always_ff @(posedge aclk)
    begin
        for (int i = 0; i < N; i++)
        begin
            if (!aresetn)
            begin
                p.pad_out[i] <= 1'b0;
                p.pad_oe[i]  <= 1'b0;
            end
            else if (p.remote[i])
            begin
                p.pad_out[i] <= p.remote_lvl[i];
                p.pad_oe[i]  <= 1'b1;
            end
            else
            begin
                unique case (pad_mode(p.dir[i], p.en[i]))
                    DDCR_PAD_FUNC:
                    begin
                        p.pad_out[i] <= p.func[i];
                        p.pad_oe[i]  <= 1'b1;
                    end
                    DDCR_PAD_TRI, DDCR_PAD_GPI:
                    begin
                        p.pad_out[i] <= 1'b0;
                        p.pad_oe[i]  <= 1'b0;
                    end
                    DDCR_PAD_GPO:
                    begin
                        p.pad_out[i] <= p.local_lvl[i];
                        p.pad_oe[i]  <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule : ddcr_pad
`default_nettype wire

// [hw/ddcr_top.sv]
// Datapath configuration and status registers with AXI4-Lite access
`timescale 1ns/1ps
`default_nettype none
`include "ddcr_defines.svh"

module ddcr_top
    import ddcr_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter int NPIN   = 2
)(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
    input  wire logic [2:0]          s_axi_awprot,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [ADDR_W-1:0]   s_axi_araddr,
    input  wire logic [2:0]          s_axi_arprot,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    input  wire logic                link_load,
    input  wire ddcr_pkg::ddcr_byte_t link_dp_ctl,
    input  wire ddcr_pkg::ddcr_byte_t link_dp_ctl2,
    input  wire logic                link_has_protection,
    input  wire logic [NPIN-1:0]     remote_pin_level,
    input  wire logic [NPIN-1:0]     func_pin_out,
    output logic [NPIN-1:0]          pin_out,
    output logic [NPIN-1:0]          pin_oe,
    input  wire logic [2:0]          strap_code,
    input  wire logic                strap_repeater,
    input  wire logic                selftest_pin_en,
    input  wire ddcr_pkg::ddcr_byte_t err_count_port0,
    input  wire ddcr_pkg::ddcr_byte_t err_count_port1,
    input  wire logic                line_done,
    input  wire logic                line_sum_ok,
    input  wire logic                de_in,
    input  wire logic                audio_overrun,
    input  wire logic                audio_underrun,
    output logic                     de_active,
    output logic                     pixel_passthrough,
    output logic                     audio_inband,
    output logic                     audio_four_ch,
    output logic                     video_disabled,
    output logic                     dual_lane,
    output logic                     line_checksum_fail,
    output ddcr_pkg::ddcr_rc_rate_t  rc_rate,
    output logic                     coax_mode,
    output logic                     selftest_active,
    output logic [1:0]               selftest_out_mode,
    output logic [1:0]               osc_rx_clock_rate,
    output logic                     remote_wr_req,
    output ddcr_pkg::ddcr_byte_t     remote_wr_addr,
    output ddcr_pkg::ddcr_byte_t     remote_wr_data,
    output ddcr_pkg::ddcr_byte_t     scl_high_period,
    output ddcr_pkg::ddcr_byte_t     scl_low_period,
    output logic [1:0]               audio_ctl
);
    import ddcr_pkg::*;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    ddcr_byte_t pin_cfg;
    ddcr_byte_t dp_ctl;
    ddcr_byte_t mode_ctl;
    ddcr_byte_t bist_ctl;
    ddcr_byte_t dp_ctl2;
    ddcr_byte_t psel;
    logic       prot_fail;

    logic [ADDR_W-1:0] aw_addr;
    ddcr_byte_t        w_data;
    logic              w_lane0;
    logic              aw_full;
    logic              w_full;
    logic              do_wr;
    logic [7:0]        wr_idx;
    logic              wr_hit;
    logic [7:0]        rd_idx;
    logic              rd_hit;
    ddcr_byte_t        rd_data;

    logic [2:0] strap_meta;
    logic [2:0] strap_sync;
    logic       rpt_meta;
    logic       rpt_sync;
    logic       stpin_meta;
    logic       stpin_sync;
    logic [1:0] strap_cnt;
    logic       strap_done;
    logic       st_en_q;
    logic       st_en;

    // Byte address to register index; misaligned or out of range misses
    function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
        idx_of = a[9:2];
    endfunction : idx_of

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] i;
        i = a[9:2];
        mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0) &&
                 (i == `DDCR_IDX_PINCFG || i == `DDCR_IDX_DP ||
                  i == `DDCR_IDX_MODE || i == `DDCR_IDX_BIST ||
                  i == `DDCR_IDX_ERRCNT || i == `DDCR_IDX_SCLH ||
                  i == `DDCR_IDX_SCLL || i == `DDCR_IDX_DP2 ||
                  i == `DDCR_IDX_AUD || i == `DDCR_IDX_PSEL ||
                  i == `DDCR_IDX_PROT);
    endfunction : mapped

    assign wr_idx = idx_of(aw_addr);
    assign wr_hit = mapped(aw_addr);
    assign rd_idx = idx_of(s_axi_araddr);
    assign rd_hit = mapped(s_axi_araddr);
    assign do_wr  = aw_full && w_full && !s_axi_bvalid;

    function automatic logic wr_to(input logic [7:0] idx);
        wr_to = do_wr && wr_hit && w_lane0 && (wr_idx == idx);
    endfunction : wr_to

    // Write address and data are taken in either order
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b0;
            aw_addr       <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            s_axi_awready <= 1'b0;
            aw_full       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
        end
        else if (do_wr)
            aw_full <= 1'b0;
        else
            s_axi_awready <= !aw_full && !s_axi_bvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b0;
            w_data       <= '0;
            w_lane0      <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            s_axi_wready <= 1'b0;
            w_full       <= 1'b1;
            w_data       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
        end
        else if (do_wr)
            w_full <= 1'b0;
        else
            s_axi_wready <= !w_full && !s_axi_bvalid;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end
        else if (do_wr)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // Read data mux
    always_comb
    begin
        rd_data = '0;
        unique case (rd_idx)
            `DDCR_IDX_PINCFG: rd_data = pin_cfg;
            `DDCR_IDX_DP:     rd_data = dp_ctl;
            `DDCR_IDX_MODE:   rd_data = mode_ctl;
            `DDCR_IDX_BIST:   rd_data = bist_ctl;
            `DDCR_IDX_ERRCNT: rd_data = psel[`DDCR_B_P1SEL] ? err_count_port1
                                                          : err_count_port0;
            `DDCR_IDX_SCLH:   rd_data = scl_high_period;
            `DDCR_IDX_SCLL:   rd_data = scl_low_period;
            `DDCR_IDX_DP2:    rd_data = dp_ctl2;
            `DDCR_IDX_AUD:    rd_data = {4'h0, audio_overrun, audio_underrun, audio_ctl};
            `DDCR_IDX_PSEL:   rd_data = psel;
            `DDCR_IDX_PROT:   rd_data = {7'h00, prot_fail};
            default:          rd_data = '0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_hit ? rd_data : 8'h00};
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end
        else if (s_axi_rvalid)
        begin
            if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
        else
            s_axi_arready <= 1'b1;
    end

    // Strap and self-test pin synchronisers
    always_ff @(posedge aclk)
    begin
        strap_meta <= strap_code;
        strap_sync <= strap_meta;
        rpt_meta   <= strap_repeater;
        rpt_sync   <= rpt_meta;
        stpin_meta <= selftest_pin_en;
        stpin_sync <= stpin_meta;
    end

    // Strap capture waits for the synchronisers to fill after release
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            strap_cnt  <= '0;
            strap_done <= 1'b0;
        end
        else if (!strap_done)
        begin
            strap_cnt  <= strap_cnt + 2'h1;
            strap_done <= (strap_cnt == `DDCR_STRAP_SETTLE);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pin_cfg <= `DDCR_RST_PINCFG;
        else if (wr_to(`DDCR_IDX_PINCFG))
            pin_cfg <= w_data;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dp_ctl <= `DDCR_RST_DP;
        else if (wr_to(`DDCR_IDX_DP))
            dp_ctl <= w_data;
        else if (link_load && !dp_ctl[`DDCR_B_OVR])
            dp_ctl <= {1'b0, link_dp_ctl[6:0]};
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            dp_ctl2 <= `DDCR_RST_DP2;
        else
        begin
            if (wr_to(`DDCR_IDX_DP2))
                dp_ctl2 <= (w_data & `DDCR_MASK_DP2_WR) |
                           (dp_ctl2 & ~`DDCR_MASK_DP2_WR);
            else if (link_load && !dp_ctl2[`DDCR_B_OVR])
                dp_ctl2 <= {1'b0, link_dp_ctl2[6:0]};
            if (link_load)
                dp_ctl2[`DDCR_B_DUAL] <= link_dp_ctl2[`DDCR_B_DUAL];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            mode_ctl <= `DDCR_RST_MODE;
        else if (wr_to(`DDCR_IDX_MODE))
            mode_ctl <= w_data;
        else if (strap_cnt == `DDCR_STRAP_SETTLE && !strap_done)
        begin
            mode_ctl[`DDCR_B_COAX] <= strap_sync[0];
            mode_ctl[`DDCR_B_FAST] <= strap_sync[1];
            mode_ctl[`DDCR_B_RPT]  <= rpt_sync;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bist_ctl <= `DDCR_RST_BIST;
        else if (wr_to(`DDCR_IDX_BIST))
            bist_ctl <= w_data;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            scl_high_period <= `DDCR_RST_SCLH;
            scl_low_period  <= `DDCR_RST_SCLL;
        end
        else
        begin
            if (wr_to(`DDCR_IDX_SCLH))
                scl_high_period <= w_data;
            if (wr_to(`DDCR_IDX_SCLL))
                scl_low_period <= w_data;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            psel      <= `DDCR_RST_PSEL;
            audio_ctl <= '0;
        end
        else
        begin
            if (wr_to(`DDCR_IDX_PSEL))
                psel <= w_data;
            if (wr_to(`DDCR_IDX_AUD))
                audio_ctl <= w_data[1:0];
        end
    end

    // Line checksum mismatch: prot_fail sticky, write one to clear, set wins; line_checksum_fail pulses one cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            prot_fail          <= 1'b0;
            line_checksum_fail <= 1'b0;
        end
        else
        begin
            line_checksum_fail <= line_done && !line_sum_ok && mode_ctl[`DDCR_B_CKSUM];
            if (line_done && !line_sum_ok && mode_ctl[`DDCR_B_CKSUM])
                prot_fail <= 1'b1;
            else if (wr_to(`DDCR_IDX_PROT) && w_data[0])
                prot_fail <= 1'b0;
        end
    end

    // Self-test enable source and clock-source push to the far end
    assign st_en = bist_ctl[`DDCR_B_PINCFG] ? stpin_sync : bist_ctl[`DDCR_B_STEN];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_en_q         <= 1'b0;
            selftest_active <= 1'b0;
            remote_wr_req   <= 1'b0;
            remote_wr_addr  <= `DDCR_REMOTE_CLKSRC_ADDR;
            remote_wr_data  <= '0;
        end
        else
        begin
            st_en_q         <= st_en;
            selftest_active <= st_en;
            remote_wr_req   <= st_en && !st_en_q;
            remote_wr_addr  <= `DDCR_REMOTE_CLKSRC_ADDR;
            if (st_en && !st_en_q)
                remote_wr_data <= {6'h00, bist_ctl[2:1]};
        end
    end

    // Datapath and mode outputs
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            de_active         <= 1'b0;
            pixel_passthrough <= 1'b0;
            audio_inband      <= 1'b0;
            audio_four_ch     <= 1'b0;
            video_disabled    <= 1'b0;
            dual_lane         <= 1'b0;
            rc_rate           <= DDCR_RC_DIV4;
            coax_mode         <= 1'b0;
            selftest_out_mode <= '0;
            osc_rx_clock_rate <= '0;
        end
        else
        begin
            de_active         <= de_in ^ dp_ctl[`DDCR_B_DEINV];
            pixel_passthrough <= dp_ctl[`DDCR_B_PASS] && link_has_protection;
            audio_inband      <= dp_ctl[`DDCR_B_AUDT];
            audio_four_ch     <= dp_ctl[`DDCR_B_AUD4];
            video_disabled    <= dp_ctl2[`DDCR_B_VDIS];
            dual_lane         <= dp_ctl2[`DDCR_B_DUAL];
            coax_mode         <= mode_ctl[`DDCR_B_COAX];
            selftest_out_mode <= bist_ctl[7:6];
            osc_rx_clock_rate <= bist_ctl[5:4];
            if (mode_ctl[`DDCR_B_FAST])
                rc_rate <= DDCR_RC_FAST;
            else if (mode_ctl[`DDCR_B_DIV])
                rc_rate <= DDCR_RC_DIV2;
            else
                rc_rate <= DDCR_RC_DIV4;
        end
    end

    // Pin configuration to the pad logic
    ddcr_pad_if #(.N(NPIN)) pads ();

    assign pads.en         = {pin_cfg[4], pin_cfg[0]};
    assign pads.dir        = {pin_cfg[5], pin_cfg[1]};
    assign pads.remote     = {pin_cfg[6], pin_cfg[2]};
    assign pads.local_lvl  = {pin_cfg[7], pin_cfg[3]};
    assign pads.remote_lvl = remote_pin_level;
    assign pads.func       = func_pin_out;
    assign pin_out         = pads.pad_out;
    assign pin_oe          = pads.pad_oe;

    ddcr_pad #(.N(NPIN)) u_pad (
        .aclk    (aclk),
        .aresetn (aresetn),
        .p       (pads.pad)
    );
endmodule : ddcr_top
`default_nettype wire

// [verification/ddcr_sva.sv]
// Port-level checker for the configuration register block
`timescale 1ns/1ps
`default_nettype none
module ddcr_sva
    import ddcr_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic de_in,
    input wire logic de_active,
    input wire logic line_done,
    input wire logic line_sum_ok,
    input wire logic line_checksum_fail,
    input wire logic remote_wr_req,
    input wire ddcr_pkg::ddcr_byte_t remote_wr_addr,
    input wire ddcr_pkg::ddcr_byte_t scl_high_period,
    input wire ddcr_pkg::ddcr_byte_t scl_low_period
);
    import ddcr_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_rwait;
        s_axi_rvalid && !s_axi_rready;
    endsequence
    sequence s_pulse;
        remote_wr_req ##1 !remote_wr_req;
    endsequence
    AST_RHOLD:
        assert property (s_rwait |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer dropped");
    AST_BHOLD:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped");
    AST_ARBLK:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while answering");
    AST_SCL_RST:
        assert property ($rose(aresetn) |-> scl_high_period == 8'h83 && scl_low_period == 8'h84)
        else $error("clock periods not at reset value");
    AST_CLKSRC_ADDR:
        assert property (remote_wr_req |-> remote_wr_addr == 8'h14)
        else $error("remote write to wrong place");
    AST_REQ_PULSE:
        assert property (remote_wr_req |-> s_pulse)
        else $error("remote write not one cycle");
    AST_CKSUM_CAUSE:
        assert property (line_checksum_fail |-> $past(line_done) && !$past(line_sum_ok))
        else $error("checksum fail without bad line");
    AST_DE_FOLLOW:
        assert property ($changed(de_in) |=> $changed(de_active))
        else $error("data enable not followed");
endmodule : ddcr_sva
bind ddcr_top ddcr_sva u_sva (.*);
`default_nettype wire

// [verification/ddcr_far_model.sv]
// Far-end serializer model: link words, pin levels, remote writes
`timescale 1ns/1ps
`default_nettype none
module ddcr_far_model
    import ddcr_pkg::*;
(
    input wire logic aclk,
    input wire logic remote_wr_req,
    input wire ddcr_pkg::ddcr_byte_t remote_wr_addr,
    input wire ddcr_pkg::ddcr_byte_t remote_wr_data,
    output logic link_load,
    output ddcr_pkg::ddcr_byte_t link_dp_ctl,
    output ddcr_pkg::ddcr_byte_t link_dp_ctl2,
    output logic [1:0] remote_pin_level
);
    import ddcr_pkg::*;
    ddcr_byte_t clk_src = 8'hFF;
    initial
    begin
        link_load = 1'b0;
        link_dp_ctl = 8'h00;
        link_dp_ctl2 = 8'h00;
        remote_pin_level = 2'h1;
    end
    always @(posedge aclk)
        if (remote_wr_req && remote_wr_addr == 8'h14)
            clk_src <= remote_wr_data;
    // Link words idle inverted after each one-cycle load
    task automatic send(input ddcr_byte_t a, input ddcr_byte_t b);
        link_dp_ctl <= a;
        link_dp_ctl2 <= b;
        link_load <= 1'b1;
        @(posedge aclk);
        link_load <= 1'b0;
        link_dp_ctl <= ~a;
        link_dp_ctl2 <= ~b;
    endtask : send
endmodule : ddcr_far_model
`default_nettype wire

// [verification/tb.sv]
// Register block testbench with AXI4-Lite bus tasks
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ddcr_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, de_in = 1'b0;
    logic link_has_protection = 1'b1, line_done = 1'b0, line_sum_ok = 1'b1;
    logic strap_repeater = 1'b0, selftest_pin_en = 1'b0, audio_overrun = 1'b1;
    logic audio_underrun = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, link_load, de_active, pixel_passthrough, audio_inband;
    logic audio_four_ch, video_disabled, dual_lane, line_checksum_fail, coax_mode;
    logic selftest_active, remote_wr_req;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, strap_code = 3'h3;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] func_pin_out = 2'h0, s_axi_bresp, s_axi_rresp, pin_out, pin_oe;
    logic [1:0] remote_pin_level, selftest_out_mode, osc_rx_clock_rate, audio_ctl;
    ddcr_byte_t err_count_port0 = 8'h5A, err_count_port1 = 8'hA5, link_dp_ctl;
    ddcr_byte_t link_dp_ctl2, remote_wr_addr, remote_wr_data, scl_high_period, scl_low_period;
    ddcr_rc_rate_t rc_rate;
    int num_errors = 0, total_checks = 0;
    logic [7:0] pcfg [5] = '{8'h99, 8'h22, 8'h44, 8'h33, 8'h88};
    logic [3:0] pexp [5] = '{4'hF, 4'h0, 4'hD, 4'h0, 4'hC};
    ddcr_top dut (.*);
    ddcr_far_model far (.*);
    always #50 aclk = ~aclk;
    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(inout int n);
        @(posedge aclk);
        n++;
        if (n > 64)
        begin
            num_errors++;
            report_and_stop();
        end
    endtask : tick
    task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er = 2'h0);
        int n;
        logic a, w;
        n = 0;
        a = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= {2'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(a && w))
        begin
            tick(n);
            a = a | s_axi_awready;
            w = w | s_axi_wready;
            s_axi_awvalid <= !a;
            s_axi_wvalid <= !w;
        end
        while (!s_axi_bvalid)
            tick(n);
        s_axi_bready <= 1'b1;
        tick(n);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [31:0] ed, input logic [1:0] er = 2'h0);
        int n;
        n = 0;
        s_axi_araddr <= {2'h0, i, 2'h0};
        s_axi_arvalid <= 1'b1;
        tick(n);
        while (!s_axi_arready)
            tick(n);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid)
            tick(n);
        s_axi_rready <= 1'b1;
        tick(n);
        chk(s_axi_rdata, ed);
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask : rd
    initial
    begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(8'h22, 32'h00);
        rd(8'h23, 32'h38);
        rd(8'h24, 32'h08);
        rd(8'h25, 32'h5A);
        rd(8'h27, 32'h84);
        rd(8'h30, 32'h00, 2'h3);
        wr(8'h30, 8'h11, 2'h3);
        chk({rc_rate, coax_mode}, {DDCR_RC_FAST, 1'b1});
        foreach (pcfg[k])
        begin
            wr(8'h21, pcfg[k]);
            chk({pin_oe, pin_out & pin_oe}, pexp[k]);
        end
        far.send(8'h63, 8'h20);
        rd(8'h22, 32'h63);
        chk({pixel_passthrough, audio_inband, audio_four_ch}, 3'h7);
        de_in <= 1'b1;
        repeat (2) @(posedge aclk);
        chk(de_active, 1'b0);
        de_in <= 1'b0;
        wr(8'h22, 8'h80);
        wr(8'h28, 8'hFF);
        far.send(8'h01, 8'h10);
        rd(8'h22, 32'h80);
        rd(8'h28, 32'hFF);
        chk({video_disabled, dual_lane}, 2'h3);
        wr(8'h23, 8'h80);
        line_sum_ok <= 1'b0;
        line_done <= 1'b1;
        @(posedge aclk);
        line_done <= 1'b0;
        line_sum_ok <= 1'b1;
        @(posedge aclk);
        chk(line_checksum_fail, 1'b1);
        rd(8'h50, 32'h01);
        wr(8'h50, 8'h01);
        rd(8'h50, 32'h00);
        wr(8'h23, 8'h48);
        chk({rc_rate, coax_mode}, {DDCR_RC_DIV2, 1'b1});
        wr(8'h23, 8'h50);
        chk({rc_rate, coax_mode}, {DDCR_RC_FAST, 1'b0});
        wr(8'h34, 8'h02);
        rd(8'h25, 32'hA5);
        wr(8'h2B, 8'h0E);
        rd(8'h2B, 32'h0A);
        chk(audio_ctl, 2'h2);
        wr(8'h24, 8'h64);
        wr(8'h24, 8'h65);
        repeat (3) @(posedge aclk);
        chk(far.clk_src, 8'h02);
        chk({selftest_active, selftest_out_mode, osc_rx_clock_rate}, 5'h16);
        wr(8'h26, 8'h5C);
        chk(scl_high_period, 8'h5C);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(8'h26, 32'h83);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
